/* verilog/mbpwm_pkg.sv */
// Shared constants for the match based PWM edge controller
package mbpwm_pkg;

    // Counter and prescaler width
    localparam int unsigned COUNT_W      = 32;
    // Number of match registers, index 0 is the cycle period match
    localparam int unsigned NUM_MATCH    = 7;
    // Number of PWM outputs, numbered 1 to NUM_MATCH-1
    localparam int unsigned NUM_OUT      = 6;
    // First output that may run in double edge mode
    localparam int unsigned FIRST_DOUBLE = 2;
    // Index of the cycle period match register
    localparam int unsigned CYCLE_IDX    = 0;

    // Values after reset
    localparam logic [31:0] RST_COUNT    = 32'h0000_0000;
    localparam logic [31:0] RST_PRESCALE = 32'h0000_0000;
    localparam logic [31:0] RST_MATCH    = 32'h0000_0000;
    localparam logic        RST_PWM      = 1'h0;
    localparam logic        RST_PENDING  = 1'h0;

    // Step of the counter on each tick and of the prescaler on each enabled clock
    localparam logic [31:0] COUNT_STEP   = 32'h0000_0001;

    // Edge mode of one output
    typedef enum logic {
        MBPWM_SINGLE_EDGE,
        MBPWM_DOUBLE_EDGE
    } mbpwm_edge_e;

endpackage : mbpwm_pkg

/* verilog/mbpwm_edge_core.sv */
`timescale 1ns/100ps
module mbpwm_edge_core #(
    parameter int unsigned COUNT_W   = mbpwm_pkg::COUNT_W,
    parameter int unsigned NUM_MATCH = mbpwm_pkg::NUM_MATCH
) (
    input  wire logic                           i_ref_clk,
    input  wire logic                           i_srst,
    input  wire logic                           i_count_en,
    input  wire logic                           i_count_clear,
    input  wire logic                           i_pwm_mode_en,
    input  wire logic [COUNT_W-1:0]             i_prescale_max,
    input  wire logic [NUM_MATCH-1:0][COUNT_W-1:0] i_match_value,
    input  wire logic [NUM_MATCH-1:0]           i_match_release,
    input  wire logic [NUM_MATCH-1:1]           i_out_en,
    input  wire logic [NUM_MATCH-1:1]           i_double_edge_sel,
    output logic      [NUM_MATCH-1:1]           o_pwm,
    output logic      [COUNT_W-1:0]             o_count,
    output logic      [COUNT_W-1:0]             o_prescale_count,
    output logic      [NUM_MATCH-1:0]           o_match_pending,
    output logic                                o_cycle_match
);

    // Prescale counter, steps every clock while counting is enabled
    logic [COUNT_W-1:0]                 prescale_count;
    // Main timer counter
    logic [COUNT_W-1:0]                 count;
    // Match values in use by the compare logic
    logic [NUM_MATCH-1:0][COUNT_W-1:0]  active_match;
    // Released values waiting for the next cycle boundary
    logic [NUM_MATCH-1:0]               pending;
    // One clock pulse when the prescaler wraps
    logic                               tick;
    // Per register compare hit, qualified by the tick
    logic [NUM_MATCH-1:0]               match_hit;
    // Cycle match hit while in PWM mode
    logic                               cycle_hit;
    // Output registers
    logic [NUM_MATCH-1:1]               pwm;

    // Prescaler wraps at its limit and lets the counter step
    // A limit of zero steps the counter on every clock; the limit
    // is read live, so a new limit takes hold in the prescale period already running
    assign tick = i_count_en && (prescale_count == i_prescale_max);

    // Compare every active match value against the counter
    // A hit only counts on a tick, so a slow prescaler cannot fire
    // the same match on several clocks in a row
    always_comb begin
        for (int m = 0; m < NUM_MATCH; m++) begin
            match_hit[m] = tick && (count == active_match[m]);
        end
    end

    // Only PWM mode treats the first match as the period
    // In timer mode the first match is an ordinary compare and the
    // counter runs on to its natural wrap
    assign cycle_hit = i_pwm_mode_en
                       && match_hit[mbpwm_pkg::CYCLE_IDX];

    // Prescale counter
    // Clear beats counting so software gets a clean restart
    always_ff @(posedge i_ref_clk) begin
        if (i_srst || i_count_clear) begin
            // Reset or software clear
            prescale_count <= COUNT_W'(mbpwm_pkg::RST_PRESCALE);
        end else if (tick) begin
            // Wrap back to zero after the limit
            prescale_count <= COUNT_W'(mbpwm_pkg::RST_PRESCALE);
        end else if (i_count_en) begin
            // Step towards the limit
            prescale_count <= COUNT_W'(prescale_count
                                       + mbpwm_pkg::COUNT_STEP);
        end
    end

    // Main counter
    // The period restart replaces the step on the same tick, so a
    // period value of N gives N+1 counts per cycle
    always_ff @(posedge i_ref_clk) begin
        if (i_srst || i_count_clear) begin
            // Reset or software clear
            count <= COUNT_W'(mbpwm_pkg::RST_COUNT);
        end else if (cycle_hit) begin
            // Period reached, start a new PWM cycle
            count <= COUNT_W'(mbpwm_pkg::RST_COUNT);
        end else if (tick) begin
            // Free running 32-bit count, wraps naturally
            count <= COUNT_W'(count + mbpwm_pkg::COUNT_STEP);
        end
    end

    // Pending flags: a release marks a value, the boundary takes it
    // A release that lands on the boundary itself stays pending, so
    // the value is taken again at the next boundary and is never
    // lost; timer mode takes every released value on the next clock
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            // No release outstanding after reset
            pending <= '0;
        end else begin
            for (int m = 0; m < NUM_MATCH; m++) begin
                if (i_match_release[m]) begin
                    // Release wins over a load in the same clock
                    pending[m] <= 1'h1;
                end else if (cycle_hit || !i_pwm_mode_en) begin
                    // Value taken over at the boundary
                    pending[m] <= mbpwm_pkg::RST_PENDING;
                end
            end
        end
    end

    // Active match values change only on a cycle boundary in PWM mode
    // The new value is sampled on the edge that applies it, so the
    // source must hold steady from release until the boundary; this
    // keeps a half updated pair of edges out of any one cycle
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            // Start from zero match values
            active_match <= '0;
        end else begin
            for (int m = 0; m < NUM_MATCH; m++) begin
                if (pending[m] && (cycle_hit || !i_pwm_mode_en)) begin
                    // Apply the released value in step with the outputs
                    active_match[m] <= i_match_value[m];
                end
            end
        end
    end

    // One output per match register beyond the cycle match
    // A double edge output n borrows match n-1 for its rise, so
    // the output below it shares that match as its own falling edge
    generate
        for (genvar n = 1; n < NUM_MATCH; n++) begin : g_out
            // Edge mode of this output, only from the second one on
            mbpwm_pkg::mbpwm_edge_e mode;
            // Set and clear events for this output
            logic                   set_evt;
            logic                   clr_evt;

            if (n >= mbpwm_pkg::FIRST_DOUBLE) begin : g_dbl
                // Outputs 2 and up may run double edge
                assign mode = i_double_edge_sel[n]
                              ? mbpwm_pkg::MBPWM_DOUBLE_EDGE
                              : mbpwm_pkg::MBPWM_SINGLE_EDGE;
            end else begin : g_sgl
                // Output 1 has no rising edge register of its own
                assign mode = mbpwm_pkg::MBPWM_SINGLE_EDGE;
            end

            // Pick the rising and falling events from the mode
            always_comb begin
                case (mode)
                    mbpwm_pkg::MBPWM_DOUBLE_EDGE: begin
                        // Previous match raises, own match lowers
                        set_evt = match_hit[n-1];
                        clr_evt = match_hit[n];
                    end
                    default: begin
                        // Cycle match raises, own match lowers
                        set_evt = cycle_hit;
                        clr_evt = match_hit[n];
                    end
                endcase
            end

            // Output register; a fall beats a rise in the same clock
            // Equal rise and fall values therefore hold the output
            // low, which gives a clean zero duty setting
            always_ff @(posedge i_ref_clk) begin
                if (i_srst) begin
                    // Low after reset
                    pwm[n] <= mbpwm_pkg::RST_PWM;
                end else if (!i_pwm_mode_en || !i_out_en[n]) begin
                    // Disabled output or timer mode keeps the pin low
                    pwm[n] <= mbpwm_pkg::RST_PWM;
                end else if (clr_evt) begin
                    // Falling edge; order against the rise sets polarity
                    pwm[n] <= 1'h0;
                end else if (set_evt) begin
                    // Rising edge
                    pwm[n] <= 1'h1;
                end
            end
        end
    endgenerate

    // Cycle boundary pulse, registered
    // It stands one clock, in the clock in which the counter reads
    // zero and the rising edges of the single edge outputs show
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            // No boundary seen during reset
            o_cycle_match <= 1'h0;
        end else begin
            // Follow the boundary hit one clock late
            o_cycle_match <= cycle_hit;
        end
    end

    // Status outputs straight from the registers
    // Every one of them comes from a flip-flop, so none can glitch
    assign o_pwm            = pwm;
    assign o_count          = count;
    assign o_prescale_count = prescale_count;
    assign o_match_pending  = pending;

endmodule : mbpwm_edge_core

/* bench/mbpwm_edge_core_assertions.sv */
`timescale 1ns/100ps
// Port checks for the PWM edge core
module mbpwm_edge_core_assertions #(
    parameter int unsigned COUNT_W   = 32,
    parameter int unsigned NUM_MATCH = 7
) (
    input wire logic                              i_ref_clk,
    input wire logic                              i_srst,
    input wire logic                              i_count_en,
    input wire logic                              i_count_clear,
    input wire logic                              i_pwm_mode_en,
    input wire logic [COUNT_W-1:0]                i_prescale_max,
    input wire logic [NUM_MATCH-1:0][COUNT_W-1:0] i_match_value,
    input wire logic [NUM_MATCH-1:0]              i_match_release,
    input wire logic [NUM_MATCH-1:1]              i_out_en,
    input wire logic [NUM_MATCH-1:1]              i_double_edge_sel,
    input wire logic [NUM_MATCH-1:1]              o_pwm,
    input wire logic [COUNT_W-1:0]                o_count,
    input wire logic [COUNT_W-1:0]                o_prescale_count,
    input wire logic [NUM_MATCH-1:0]              o_match_pending,
    input wire logic                              o_cycle_match
);
    // Counter advances when the prescaler reaches its limit
    wire tick = i_count_en && (o_prescale_count == i_prescale_max);
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_srst);
    // Release seen in PWM mode
    sequence s_rel1; i_pwm_mode_en && i_match_release[1]; endsequence
    // Wrap pulse that belongs to a PWM boundary one edge back
    sequence s_wrap; o_cycle_match && $past(i_pwm_mode_en); endsequence
    property p_pend; s_rel1 |=> o_match_pending[1]; endproperty
    a_pend: assert property (p_pend) else $error("no pending");
    property p_cyc;
        s_wrap |-> o_count == '0 && o_prescale_count == '0;
    endproperty
    a_cyc: assert property (p_cyc) else $error("no wrap");
    property p_drop;
        s_wrap |-> o_match_pending == $past(i_match_release);
    endproperty
    a_drop: assert property (p_drop) else $error("stale pending");
    property p_rise; $rose(o_pwm[1]) |-> o_cycle_match; endproperty
    a_rise: assert property (p_rise) else $error("late rise");
    property p_off; !i_pwm_mode_en |=> o_pwm == '0; endproperty
    a_off: assert property (p_off) else $error("timer pwm");
    property p_en; i_pwm_mode_en |=> (o_pwm & ~$past(i_out_en)) == '0;
    endproperty
    a_en: assert property (p_en) else $error("disabled high");
    property p_step;
        tick && !i_pwm_mode_en && !i_count_clear |=>
            o_count == $past(o_count) + 1'b1;
    endproperty
    a_step: assert property (p_step) else $error("bad step");
    property p_clr;
        i_count_clear |=> o_count == '0 && o_prescale_count == '0;
    endproperty
    a_clr: assert property (p_clr) else $error("no clear");
endmodule : mbpwm_edge_core_assertions

/* bench/mbpwm_edge_core_tb.sv */
`timescale 1ns/100ps
// Self-checking bench for the PWM edge core
module mbpwm_edge_core_tb;
    logic             i_ref_clk, i_srst, i_count_en, i_count_clear;
    logic             i_pwm_mode_en, o_cycle_match;
    logic [31:0]      i_prescale_max, o_count, o_prescale_count;
    logic [6:0][31:0] i_match_value;
    logic [6:0]       i_match_release, o_match_pending;
    logic [6:1]       i_out_en, i_double_edge_sel, o_pwm;
    int               bad_count = 0, check_count = 0, cyc = 0;
    mbpwm_edge_core i_mbpwm_edge_core (
        .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_count_en(i_count_en),
        .i_count_clear(i_count_clear), .i_pwm_mode_en(i_pwm_mode_en),
        .i_prescale_max(i_prescale_max), .i_match_value(i_match_value),
        .i_match_release(i_match_release), .i_out_en(i_out_en),
        .i_double_edge_sel(i_double_edge_sel), .o_pwm(o_pwm),
        .o_count(o_count), .o_prescale_count(o_prescale_count),
        .o_match_pending(o_match_pending), .o_cycle_match(o_cycle_match));
    // 250 MHz clock
    initial begin
        i_ref_clk = 1'h0;
        forever #2 i_ref_clk = ~i_ref_clk;
    end
    // Hang guard
    always @(posedge i_ref_clk) begin
        cyc++;
        if (cyc == 1000) begin
            bad_count++;
            $display("[FAIL] %0t timeout", $time);
            summarize();
        end
    end
    task automatic chk(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'h1) begin
            bad_count++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask : step
    // Sets matches 0..2 and loads all seven in timer mode, then restarts in PWM mode
    task automatic load(input logic [31:0] m0, m1, m2, input logic dbl);
        i_pwm_mode_en = 1'h0;
        i_match_value[2:0] = {m2, m1, m0};
        i_double_edge_sel = {4'h0, dbl, 1'h0};
        i_match_release = 7'h7F;
        step(1);
        i_match_release = 7'h00;
        i_count_clear = 1'h1;
        step(1);
        i_count_clear = 1'h0;
        i_pwm_mode_en = 1'h1;
    endtask : load
    // High cycles of one output over two periods of five
    task automatic duty(input int b, input int exp);
        int n;
        n = 0;
        step(10);
        repeat (10) begin
            n += (o_pwm[b] === 1'h1);
            step(1);
        end
        chk(n == exp, "duty");
    endtask : duty
    task automatic t_single();
        load(32'h4, 32'h1, 32'h3, 1'h0);
        duty(1, 4);
        duty(2, 8);
    endtask : t_single
    task automatic t_double();
        load(32'h4, 32'h1, 32'h3, 1'h1);
        duty(2, 4);
        load(32'h4, 32'h3, 32'h1, 1'h1);
        duty(2, 6);
    endtask : t_double
    // Three double edge outputs side by side, one negative going
    task automatic t_multi();
        i_match_value[6:3] = {32'h1, 32'h3, 32'h2, 32'h0};
        step(1);
        load(32'h4, 32'h1, 32'h3, 1'h1);
        i_double_edge_sel = 6'h2A;
        duty(2, 4);
        duty(4, 4);
        duty(6, 6);
    endtask : t_multi
    task automatic t_pend();
        load(32'h4, 32'h1, 32'h3, 1'h0);
        step(3);
        i_match_value[1] = 32'h2;
        i_match_release = 7'h02;
        step(1);
        i_match_release = 7'h00;
        chk(o_match_pending[1] === 1'h1, "pending");
        step(6);
        chk(o_match_pending[1] === 1'h0, "applied");
        duty(1, 6);
        i_out_en = 6'h3E;
        step(2);
        chk(o_pwm[1] === 1'h0, "disabled");
        i_out_en = 6'h3F;
    endtask : t_pend
    task automatic t_timer();
        i_pwm_mode_en = 1'h0;
        i_prescale_max = 32'h2;
        i_count_clear = 1'h1;
        step(1);
        i_count_clear = 1'h0;
        step(9);
        chk(o_count === 32'h3 && o_pwm === 6'h0, "timer");
        i_count_en = 1'h0;
        step(4);
        chk(o_count === 32'h3, "hold");
    endtask : t_timer
    task automatic summarize();
        if (bad_count == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize
    initial begin
        {i_srst, i_count_en, i_count_clear, i_pwm_mode_en} = 4'hC;
        {i_prescale_max, i_match_value, i_match_release} = '0;
        {i_out_en, i_double_edge_sel} = 12'hFC0;
        step(4);
        i_srst = 1'h0;
        t_single();
        t_double();
        t_multi();
        t_pend();
        t_timer();
        summarize();
    end
endmodule : mbpwm_edge_core_tb
bind mbpwm_edge_core mbpwm_edge_core_assertions #(
    .COUNT_W(COUNT_W), .NUM_MATCH(NUM_MATCH)
) i_mbpwm_edge_core_assertions (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_count_en(i_count_en),
    .i_count_clear(i_count_clear), .i_pwm_mode_en(i_pwm_mode_en),
    .i_prescale_max(i_prescale_max), .i_match_value(i_match_value),
    .i_match_release(i_match_release), .i_out_en(i_out_en),
    .i_double_edge_sel(i_double_edge_sel), .o_pwm(o_pwm),
    .o_count(o_count), .o_prescale_count(o_prescale_count),
    .o_match_pending(o_match_pending), .o_cycle_match(o_cycle_match));
